/* File: src/apr_pkg.sv */
// Package with constants, types and the rule summary for the converter read-port host controller
// Rules for the converter interface
// - Chip select may be held low for good, and then read alone controls the transfer.
// - A logic host may use the end-of-conversion pulse itself as chip select and read.
// - A processor host may treat the falling end-of-conversion edge as a result-ready interrupt.
// - The host may drive channel select from the three low address lines, sampled with read.
// - Chip select decoding uses only host address bits 3 to 15, so channel bits do not change selection.
// - Without power-down the host waits 30 ns after a read ends before starting a new conversion.
package apr_pkg;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int DATA_W          = 8;
  localparam int CHAN_W          = 3;
  localparam int FIFO_DEPTH      = 32;
  localparam int EOC_MAX_NS      = 110;
  localparam int SAMPLE_MAX_NS   = 530;
  localparam int READ_GAP_NS     = 30;
  localparam int CONV_LOW_NS     = 40;
  localparam int READ_LOW_NS     = 80;
  localparam int TIMEOUT_CYC     = (SAMPLE_MAX_NS + EOC_MAX_NS) / CLK_PERIOD_NS;
  localparam int GAP_CYC         = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_LOW_CYC    = (CONV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_LOW_CYC    = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 5;
  localparam logic [1:0] SRC_EOC = 2'h0;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } apr_sample_s;

  typedef enum logic [2:0] {
    APR_IDLE, APR_CONV, APR_WAIT_EOC, APR_READ, APR_GAP
  } apr_state_e;
endpackage : apr_pkg

/* File: src/apr_fifo.sv */
// Parameterised valid/ready FIFO for captured samples
`timescale 1ns/1ns
module apr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  always_comb begin
    push     = in_valid && (cnt_reg != (AW+1)'(DEPTH));
    pop      = out_valid && out_ready;
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rd_reg];
endmodule : apr_fifo

/* File: src/apr_host.sv */
// Host controller that starts conversions, reads results and queues them
`timescale 1ns/1ns
module apr_host
  import apr_pkg::*;
#(
  parameter int DEPTH = apr_pkg::FIFO_DEPTH
) (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      start,
  input  wire logic                      auto_power_down,
  input  wire logic [apr_pkg::CHAN_W-1:0] next_chan,
  output logic                           busy,
  output logic                           timeout,
  output logic                           convert_start_n,
  output logic                           cs_n,
  output logic                           rd_n,
  output logic [apr_pkg::CHAN_W-1:0]     channel_sel,
  input  wire logic                      eoc_n,
  input  wire logic [apr_pkg::DATA_W-1:0] db_in,
  output logic                           sample_valid,
  input  wire logic                      sample_ready,
  output apr_pkg::apr_sample_s           sample
);
  import apr_pkg::*;

  apr_state_e        st_reg, st_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic              conv_reg, conv_next, rd_reg, rd_next, to_reg, to_next;
  logic [CHAN_W-1:0] ch_reg, ch_next, cur_reg, cur_next;
  logic [1:0]        eoc_sync;
  logic [DATA_W-1:0] db_s1, db_s2;
  logic              eoc_prev, eoc_fall, push, f_ready;
  apr_sample_s       push_data;

  // Two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge core_clk) begin
    if (srst) begin
      eoc_sync <= 2'h3;
      eoc_prev <= 1'b1;
      db_s1    <= '0;
      db_s2    <= '0;
    end else begin
      eoc_sync <= {eoc_sync[0], eoc_n};
      eoc_prev <= eoc_sync[1];
      db_s1    <= db_in;
      db_s2    <= db_s1;
    end
  end
  assign eoc_fall  = eoc_prev && !eoc_sync[1];

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    conv_next = conv_reg;
    rd_next   = rd_reg;
    to_next   = 1'b0;
    ch_next   = ch_reg;
    cur_next  = cur_reg;
    push      = 1'b0;
    case (st_reg)
      APR_IDLE: begin
        if (start && f_ready) begin
          conv_next = 1'b0;
          cnt_next  = CNT_W'(CONV_LOW_CYC);
          st_next   = APR_CONV;
        end
      end
      APR_CONV: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == CNT_W'(1)) begin
          // Power-down keeps the strobe low past end-of-conversion
          conv_next = !auto_power_down;
          cnt_next  = CNT_W'(TIMEOUT_CYC + 4);
          st_next   = APR_WAIT_EOC;
        end
      end
      APR_WAIT_EOC: begin
        cnt_next = cnt_reg - 1'b1;
        if (eoc_fall) begin
          rd_next  = 1'b0;
          // Tag the word with the channel in force before this read relatches it
          cur_next = ch_reg;
          ch_next  = next_chan;
          cnt_next = CNT_W'(READ_LOW_CYC);
          st_next  = APR_READ;
        end else if (cnt_reg == '0) begin
          to_next   = 1'b1;
          conv_next = 1'b1;
          st_next   = APR_IDLE;
        end
      end
      APR_READ: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == CNT_W'(1)) begin
          rd_next   = 1'b1;
          conv_next = 1'b1;
          push      = 1'b1;
          cnt_next  = CNT_W'(GAP_CYC);
          st_next   = APR_GAP;
        end
      end
      APR_GAP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg <= CNT_W'(1)) begin
          st_next = APR_IDLE;
        end
      end
      default: st_next = APR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg   <= APR_IDLE;
      cnt_reg  <= '0;
      conv_reg <= 1'b1;
      rd_reg   <= 1'b1;
      to_reg   <= 1'b0;
      ch_reg   <= '0;
      cur_reg  <= '0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      conv_reg <= conv_next;
      rd_reg   <= rd_next;
      to_reg   <= to_next;
      ch_reg   <= ch_next;
      cur_reg  <= cur_next;
    end
  end

  // Data sampled one cycle into the two-cycle read window, after two flops of settling
  assign push_data = '{chan: cur_reg, data: db_s2};

  // The second sync stage only holds read data one edge after the read ends, so the push is delayed by one
  logic push_reg;
  logic busy_reg;
  logic busy_next;
  always_comb begin
    busy_next = st_next != APR_IDLE;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      push_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      push_reg <= push;
      busy_reg <= busy_next;
    end
  end

  apr_fifo #(.WIDTH(CHAN_W + DATA_W), .DEPTH(DEPTH)) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .in_valid (push_reg),
    .in_ready (f_ready),
    .in_data  (push_data),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data (sample)
  );

  assign convert_start_n = conv_reg;
  assign rd_n            = rd_reg;
  assign cs_n            = rd_reg;
  assign channel_sel     = ch_reg;
  assign busy            = busy_reg;
  assign timeout         = to_reg;
endmodule : apr_host

/* File: verification/apr_host_asserts.sv */
// Pin-level checker for the converter host controller
`timescale 1ns/1ns
module apr_host_asserts
  import apr_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       start,
  input wire logic       auto_power_down,
  input wire logic [2:0] next_chan,
  input wire logic       busy,
  input wire logic       timeout,
  input wire logic       convert_start_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic [2:0] channel_sel,
  input wire logic       eoc_n,
  input wire logic       sample_valid,
  input wire logic       sample_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_cs_rd_same: assert property (cs_n == rd_n) else $error("cs_n and rd_n differ");
  a_conv_cause: assert property ($fell(convert_start_n) |-> $past(start)) else $error("unrequested conversion");
  a_read_after_eoc: assert property ($fell(eoc_n) |-> ##[1:5] !rd_n) else $error("no read after eoc");
  a_read_length: assert property ($fell(rd_n) |=> !rd_n ##1 rd_n) else $error("read not two cycles");
  a_fast_pulse: assert property ($fell(convert_start_n) && !auto_power_down |=> convert_start_n)
    else $error("convert pulse too long");
  a_pd_hold: assert property ($fell(convert_start_n) && auto_power_down |=> !convert_start_n)
    else $error("convert not held low");
  a_read_gap: assert property ($rose(rd_n) |-> convert_start_n [*2]) else $error("convert too soon after read");
  a_chan_latch: assert property ($fell(rd_n) |-> channel_sel == $past(next_chan)) else $error("channel not latched");
  a_timeout_idle: assert property (timeout |=> !busy) else $error("busy after timeout");
  cover property (timeout);
  cover property (sample_valid && sample_ready);
  cover property ($fell(convert_start_n) && auto_power_down);
endmodule : apr_host_asserts
bind apr_host apr_host_asserts u_apr_host_asserts (.core_clk(core_clk), .srst(srst), .start(start),
  .auto_power_down(auto_power_down), .next_chan(next_chan), .busy(busy), .timeout(timeout),
  .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n), .channel_sel(channel_sel), .eoc_n(eoc_n),
  .sample_valid(sample_valid), .sample_ready(sample_ready));

/* File: verification/apr_dev_model.sv */
// Behavioural model of the eight-channel converter behind the host pins
`timescale 1ns/1ns
module apr_dev_model (
  input  wire logic       convert_start_n,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic [2:0] channel_sel,
  input  wire logic       mute,
  input  wire logic [1:0] conv_cyc,
  output logic            eoc_n,
  output logic      [7:0] db_in
);
  logic [2:0] mux_reg = 3'h0;
  logic [2:0] conv_chan;
  logic [4:0] cnt     = 5'h0;
  logic [7:0] out_reg = 8'h00;
  logic       pd      = 1'b0;
  initial eoc_n = 1'b1;
  always @(negedge rd_n) if (!cs_n) mux_reg = channel_sel;
  always @(negedge convert_start_n) if (!mute) begin
    conv_chan = mux_reg;
    #(200 + 40 * conv_cyc);
    out_reg = {conv_chan, cnt};
    cnt++;
    eoc_n = 1'b0;
    #100 eoc_n = 1'b1;
    pd = !convert_start_n;
  end
  always @(posedge rd_n) eoc_n = 1'b1;
  // Released lines show the inverse so a late sample cannot match by chance
  assign db_in = (!cs_n && !rd_n) ? out_reg : ~out_reg;
endmodule : apr_dev_model

/* File: verification/tb.sv */
// Self-checking bench for the converter host controller
`timescale 1ns/1ns
module tb;
  import apr_pkg::*;
  logic        core_clk = 0, srst = 1, start = 0, apd = 0, sample_ready = 0, mute = 0, to_seen = 0;
  logic [2:0]  next_chan = 0, exp_chan = 0, channel_sel;
  logic [1:0]  conv_cyc = 0;
  logic [4:0]  exp_cnt = 0;
  logic [7:0]  db_in;
  logic [31:0] seed = 32'h5C403A76;
  logic        busy, timeout, convert_start_n, cs_n, rd_n, eoc_n, sample_valid;
  apr_sample_s sample;
  apr_sample_s exp_q[$];
  int          n_errors = 0, checked = 0, cyc = 0, i;
  always #20 core_clk = ~core_clk;
  apr_host u_apr_host (.core_clk(core_clk), .srst(srst), .start(start), .auto_power_down(apd),
    .next_chan(next_chan), .busy(busy), .timeout(timeout), .convert_start_n(convert_start_n), .cs_n(cs_n),
    .rd_n(rd_n), .channel_sel(channel_sel), .eoc_n(eoc_n), .db_in(db_in), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample(sample));
  apr_dev_model u_apr_dev_model (.convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .channel_sel(channel_sel), .mute(mute), .conv_cyc(conv_cyc), .eoc_n(eoc_n), .db_in(db_in));
  function void rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction : rnd
  task chk(input logic [10:0] g, input logic [10:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wrap_up();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (timeout === 1'b1) to_seen <= 1'b1;
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(sample, ~sample);
      else chk(sample, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // Expected word is queued before the wait, since it may drain at the first edge after busy falls
  task conv(input logic [2:0] c);
    int k;
    next_chan = c;
    to_seen = 0;
    if (!mute) exp_q.push_back({exp_chan, exp_chan, exp_cnt});
    start = 1;
    @(posedge core_clk);
    #1 start = 0;
    k = 0;
    while (busy !== 1'b0 && k < 60) begin
      @(posedge core_clk);
      #1 k++;
    end
    @(posedge core_clk);
    #1 if (mute) chk(to_seen, 1'b1);
    else begin
      exp_cnt++;
      exp_chan = c;
    end
  endtask : conv
  initial begin
    repeat (10) @(posedge core_clk);
    #1 srst = 0;
    sample_ready = 1;
    for (i = 0; i < 16; i++) begin
      rnd();
      apd = seed[0];
      conv_cyc = seed[2:1];
      conv(i < 8 ? i[2:0] : seed[5:3]);
    end
    $display("test channels done");
    mute = 1;
    conv(3'h5);
    mute = 0;
    $display("test timeout done");
    sample_ready = 0;
    for (i = 0; i < 32; i++) begin
      rnd();
      conv(seed[2:0]);
    end
    start = 1;
    repeat (3) @(posedge core_clk);
    #1 start = 0;
    chk(busy, 1'b0);
    for (i = 0; i < 400 && exp_q.size() > 0; i++) begin
      rnd();
      sample_ready = seed[0];
      @(posedge core_clk);
      #1;
    end
    chk(exp_q.size(), 0);
    $display("test fifo done");
    wrap_up();
  end
endmodule : tb
